// File: eeprom_cfg_regs.vh
// Purpose: Register indices, bit positions and reset values for the EEPROM control block
// Assumes: 32-bit Avalon-MM data, 8-bit registers in the low byte of each word
// Notes: Byte address of a register is four times its index
`ifndef EEPROM_CFG_REGS_VH
`define EEPROM_CFG_REGS_VH

`define ADDR_W 10
`define IDX_W 8
`define IDX_MODCFG 8'hF0
`define IDX_TEST 8'hF1
`define IDX_DIVH 8'hF2
`define IDX_PECTRL 8'hF3
`define IDX_DIVL 8'hF4

`define MC_DBG 7
`define MC_HIDE 6
`define MC_TBIT 5
`define MC_FOPEN 4
`define MC_ONE 3
`define MC_WSTOP 2
`define MC_PLOCK 1
`define MC_SPARE 0

`define PE_GUARD 7
`define PE_AUTO 5
`define PE_BYTE 4
`define PE_ROW 3
`define PE_ERASE 2
`define PE_LATCH 1
`define PE_PGM 0

`define SH_CFG_HI 7
`define SH_CFG_LO 4
`define DIVH_W 2
`define DIV_W 10

`define RST_WSTOP 1'b1
`define RST_PLOCK 1'b0
`define RST_SPARE 1'b0
`define RST_GUARD 1'b1
`define RST_BYTE 8'h00
`define RST_DIV 10'h000
`define CFG_FIXED_ONE 1'b1

`define SHADOW_HI_ADDR 12'h0FC0
`define SHADOW_LO_ADDR 12'h0FC1
`define ARR_ADDR_W 12

`define ERASE_NONE 2'b00
`define ERASE_BYTE 2'b01
`define ERASE_ROW 2'b10
`define ERASE_BULK 2'b11

`endif

// File: level_sync2.v
// Purpose: Two-stage synchroniser for one level from outside the clock domain
// Assumes: Single clock, synchronous active-low reset
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module level_sync2 #(
	parameter RESET_VAL = 1'b1
) (
	input wire clk_i, // System clock
	input wire reset_n_i, // Synchronous reset, active low
	input wire async_i, // Level from outside the domain
	output wire sync_o // Synchronised level
);
	reg meta_r;
	reg sync_r;

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;
endmodule // level_sync2
`default_nettype wire

// File: write_once_gate.v
// Purpose: Permits one write after reset in normal mode, any number in special mode
// Assumes: wr_i pulses for one cycle per accepted bus write to the guarded field
// Notes: A write refused for other reasons must not be presented on wr_i
`timescale 1ns/1ps
`default_nettype none
module write_once_gate (
	input wire clk_i, // System clock
	input wire reset_n_i, // Synchronous reset, active low
	input wire special_i, // High in special mode
	input wire wr_i, // Write to the guarded field taken
	output wire allow_o // Write would be accepted now
);
	reg used_r;

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			used_r <= 1'b0;
		end else if (wr_i && !special_i) begin
			used_r <= 1'b1;
		end
	end

	assign allow_o = special_i || !used_r;
endmodule // write_once_gate
`default_nettype wire

// File: eeprom_config_and_control_regs.v
// Purpose: Module configuration and program/erase control registers of the EEPROM block
// Assumes: Avalon-MM slave, byte address, one wait state per access
// Notes: Shadow word is sampled on the first cycle after reset release
// Summary of operation
// - Config bits 7:4 load from shadow one cycle after reset release
// - Debug lockout disable: 0 locks, 1 frees
// - Debug and hide bits writable only special mode
// - Hide clear redirects 0FC0/0FC1 to shadow
// - Shadow bits feed config and divider registers
// - Bulk operations only with shadow word enabled
// - Flash open: special free, normal writes zero
// - Wait stop gates module clock in wait
// - Protect lock blocks guard; write-once in normal
// - Test bits dead and zero in normal
// - Guard blocks bulk/row erase; resets to one
// - Auto shutdown clears voltage enable when done
// - Row bit picks row or bulk erase
// - Voltage enable sets only after latch set
// - Voltage enable freezes the other control bits
`include "eeprom_cfg_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module eeprom_config_and_control_regs (
	input wire clk_i, // 200 MHz system clock
	input wire reset_n_i, // Synchronous reset, active low
	input wire [9:0] address_i, // Avalon byte address
	input wire read_i, // Avalon read
	input wire write_i, // Avalon write
	input wire [31:0] writedata_i, // Avalon write data
	input wire [3:0] byteenable_i, // Avalon byte enables
	output wire [31:0] readdata_o, // Avalon read data
	output wire waitrequest_o, // Avalon wait request
	input wire special_mode_n_i, // Mode pin, low in special mode
	input wire wait_mode_i, // CPU is in wait mode
	input wire cycle_done_i, // Program/erase cycle finished pulse
	input wire [7:0] shadow_high_i, // Shadow word high byte
	input wire [7:0] shadow_low_i, // Shadow word low byte
	input wire [11:0] array_addr_i, // Array address of current access
	output wire shadow_select_o, // Access goes to the shadow word
	output wire debug_lockout_o, // Debug-mode lockout active
	output wire flash_write_open_o, // Flash array may be programmed
	output wire module_clock_en_o, // Module clock running
	output wire latch_enable_o, // Address/data latches armed
	output wire program_voltage_enable_o, // Program/erase voltage applied
	output wire erase_config_o, // Erase configuration, else program
	output wire [1:0] erase_kind_o, // None, byte/word, row or bulk
	output wire pe_active_o, // Voltage on with a non-zero divider
	output wire [9:0] divider_o // Self-time prescaler value
);
	wire special_mode_n_s;
	wire special;
	wire [7:0] idx;
	wire req;
	wire wr_take;
	wire wr_lo;
	wire [7:0] wd;
	wire wr_cfg;
	wire wr_pe;
	wire wr_test;
	wire wr_divh;
	wire wr_divl;
	wire plock_allow;
	wire div_allow;
	wire div_wr;
	wire plock_wr;
	wire [7:0] cfg_view;
	wire [7:0] pe_view;

	reg waitrequest_r;
	reg [31:0] readdata_r;
	reg [7:0] rd_mux;
	reg load_pend_r;

	reg dbg_dis_r;
	reg shadow_hide_r;
	reg test_bit_r;
	reg flash_open_r;
	reg wait_stop_r;
	reg protect_lock_r;
	reg spare_r;
	reg [7:0] test_reg_r;

	reg guard_r;
	reg auto_r;
	reg byte_r;
	reg row_r;
	reg erase_r;
	reg latch_r;
	reg pgm_r;
	reg pgm_nxt;
	reg [9:0] div_r;

	reg shadow_sel_r;
	reg dbg_lock_r;
	reg fopen_out_r;
	reg clk_en_r;
	reg latch_out_r;
	reg pgm_out_r;
	reg erase_out_r;
	reg [1:0] kind_r;
	reg [1:0] kind_nxt;
	reg pe_act_r;
	reg [9:0] div_out_r;

	// Mode pin comes from outside, so it is synchronised before use
	level_sync2 #(
		.RESET_VAL(1'b1)
	) u_mode_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.async_i(special_mode_n_i),
		.sync_o(special_mode_n_s)
	);

	assign special = !special_mode_n_s;

	// Bus decode: one wait cycle, write lands on the edge waitrequest is low
	assign idx = address_i[`IDX_W+1:2];
	assign req = read_i || write_i;
	assign wr_take = write_i && !waitrequest_r;
	assign wr_lo = wr_take && byteenable_i[0];
	assign wd = writedata_i[7:0];
	assign wr_cfg = wr_lo && (idx == `IDX_MODCFG);
	assign wr_pe = wr_lo && (idx == `IDX_PECTRL);
	assign wr_test = wr_lo && (idx == `IDX_TEST);
	assign wr_divh = wr_lo && (idx == `IDX_DIVH);
	assign wr_divl = wr_lo && (idx == `IDX_DIVL);

	assign plock_wr = wr_cfg && plock_allow;
	assign div_wr = (wr_divh || wr_divl) && div_allow && !latch_r;

	write_once_gate u_plock_once (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.special_i(special),
		.wr_i(wr_cfg),
		.allow_o(plock_allow)
	);

	write_once_gate u_div_once (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.special_i(special),
		.wr_i((wr_divh || wr_divl) && !latch_r),
		.allow_o(div_allow)
	);

	assign cfg_view = {dbg_dis_r, shadow_hide_r, test_bit_r, flash_open_r,
		`CFG_FIXED_ONE, wait_stop_r, protect_lock_r, spare_r};
	assign pe_view = {guard_r, 1'b0, auto_r, byte_r, row_r, erase_r, latch_r, pgm_r};

	always @* begin
		case (idx)
			`IDX_MODCFG: rd_mux = cfg_view;
			`IDX_TEST: rd_mux = special ? test_reg_r : `RST_BYTE;
			`IDX_DIVH: rd_mux = {6'h00, div_r[`DIV_W-1:8]};
			`IDX_PECTRL: rd_mux = pe_view;
			`IDX_DIVL: rd_mux = div_r[7:0];
			default: rd_mux = `RST_BYTE;
		endcase
	end

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			waitrequest_r <= 1'b1;
			readdata_r <= 32'h0000_0000;
		end else begin
			waitrequest_r <= !(req && waitrequest_r);
			if (req && waitrequest_r) begin
				readdata_r <= {24'h00_0000, rd_mux};
			end
		end
	end

	// Configuration register; upper nibble and divider come from the shadow word
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			load_pend_r <= 1'b1;
			dbg_dis_r <= 1'b0;
			shadow_hide_r <= 1'b0;
			test_bit_r <= 1'b0;
			flash_open_r <= 1'b0;
			wait_stop_r <= `RST_WSTOP;
			protect_lock_r <= `RST_PLOCK;
			spare_r <= `RST_SPARE;
			div_r <= `RST_DIV;
		end else if (load_pend_r) begin
			// Shadow is caught one cycle after release, never under reset itself
			load_pend_r <= 1'b0;
			dbg_dis_r <= shadow_high_i[`MC_DBG];
			shadow_hide_r <= shadow_high_i[`MC_HIDE];
			test_bit_r <= shadow_high_i[`MC_TBIT];
			flash_open_r <= shadow_high_i[`MC_FOPEN];
			div_r <= {shadow_high_i[`DIVH_W-1:0], shadow_low_i};
		end else begin
			if (wr_cfg && special) begin
				dbg_dis_r <= wd[`MC_DBG];
				shadow_hide_r <= wd[`MC_HIDE];
				test_bit_r <= wd[`MC_TBIT];
			end
			if (wr_cfg && (special || !wd[`MC_FOPEN])) begin
				flash_open_r <= wd[`MC_FOPEN];
			end
			if (wr_cfg) begin
				wait_stop_r <= wd[`MC_WSTOP];
				spare_r <= wd[`MC_SPARE];
			end
			if (plock_wr) begin
				protect_lock_r <= wd[`MC_PLOCK];
			end
			if (div_wr && wr_divh) begin
				div_r[`DIV_W-1:8] <= wd[`DIVH_W-1:0];
			end
			if (div_wr && wr_divl) begin
				div_r[7:0] <= wd;
			end
		end
	end

	// Test register exists only in special mode; normal mode holds it at zero
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			test_reg_r <= `RST_BYTE;
		end else if (!special) begin
			test_reg_r <= `RST_BYTE;
		end else if (wr_test) begin
			test_reg_r <= wd;
		end
	end

	// Voltage enable: a set needs the latch already set, auto shutdown wins
	always @* begin
		pgm_nxt = pgm_r;
		if (wr_pe) begin
			pgm_nxt = wd[`PE_PGM] && latch_r;
		end
		if (auto_r && pgm_r && cycle_done_i) begin
			pgm_nxt = 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			guard_r <= `RST_GUARD;
			auto_r <= 1'b0;
			byte_r <= 1'b0;
			row_r <= 1'b0;
			erase_r <= 1'b0;
			latch_r <= 1'b0;
			pgm_r <= 1'b0;
		end else begin
			pgm_r <= pgm_nxt;
			if (wr_pe && !pgm_r) begin
				if (!protect_lock_r) begin
					guard_r <= wd[`PE_GUARD];
				end
				auto_r <= wd[`PE_AUTO];
				byte_r <= wd[`PE_BYTE];
				row_r <= wd[`PE_ROW];
				erase_r <= wd[`PE_ERASE];
				if (div_r != `RST_DIV) begin
					latch_r <= wd[`PE_LATCH];
				end
			end
		end
	end

	// Erase kind decode; guard vetoes row and bulk erase, hide bit vetoes bulk only
	always @* begin
		kind_nxt = `ERASE_NONE;
		if (erase_r) begin
			if (byte_r) begin
				kind_nxt = `ERASE_BYTE;
			end else if (!guard_r) begin
				if (row_r) begin
					kind_nxt = `ERASE_ROW;
				end else if (!shadow_hide_r) begin
					kind_nxt = `ERASE_BULK;
				end
			end
		end
	end

	// All outputs are registered, so they trail their cause by one cycle
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			shadow_sel_r <= 1'b0;
			dbg_lock_r <= 1'b1;
			fopen_out_r <= 1'b0;
			clk_en_r <= 1'b1;
			latch_out_r <= 1'b0;
			pgm_out_r <= 1'b0;
			erase_out_r <= 1'b0;
			kind_r <= `ERASE_NONE;
			pe_act_r <= 1'b0;
			div_out_r <= `RST_DIV;
		end else begin
			shadow_sel_r <= !shadow_hide_r && !load_pend_r &&
				((array_addr_i == `SHADOW_HI_ADDR) ||
				(array_addr_i == `SHADOW_LO_ADDR));
			dbg_lock_r <= !dbg_dis_r;
			fopen_out_r <= flash_open_r;
			clk_en_r <= !(wait_stop_r && wait_mode_i);
			latch_out_r <= latch_r;
			pgm_out_r <= pgm_r;
			erase_out_r <= erase_r;
			kind_r <= kind_nxt;
			// A zero divider would give no self-time clock, so no cycle starts
			pe_act_r <= pgm_r && (div_r != `RST_DIV);
			div_out_r <= div_r;
		end
	end

	assign readdata_o = readdata_r;
	assign waitrequest_o = waitrequest_r;
	assign shadow_select_o = shadow_sel_r;
	assign debug_lockout_o = dbg_lock_r;
	assign flash_write_open_o = fopen_out_r;
	assign module_clock_en_o = clk_en_r;
	assign latch_enable_o = latch_out_r;
	assign program_voltage_enable_o = pgm_out_r;
	assign erase_config_o = erase_out_r;
	assign erase_kind_o = kind_r;
	assign pe_active_o = pe_act_r;
	assign divider_o = div_out_r;
endmodule // eeprom_config_and_control_regs
`default_nettype wire

// File: eeprom_regs_chk.sv
// Purpose: Port-level assertions for the EEPROM register block
// Assumes: Mode pin passes a two-flop synchroniser before the registers
// Notes: Mode history spans synchroniser lag plus the output stage
`timescale 1ns/1ps
`default_nettype none
module eeprom_regs_chk (
	input wire clk_i, // Clock
	input wire reset_n_i, // Reset, low
	input wire [9:0] address_i, // Address
	input wire read_i, // Read
	input wire [31:0] readdata_o, // Read data
	input wire special_mode_n_i, // Mode pin
	input wire wait_mode_i, // Wait
	input wire [11:0] array_addr_i, // Array address
	input wire shadow_select_o, // Redirect
	input wire debug_lockout_o, // Lockout
	input wire flash_write_open_o, // Flash open
	input wire module_clock_en_o, // Clock enable
	input wire latch_enable_o, // Latch
	input wire program_voltage_enable_o, // Voltage
	input wire erase_config_o, // Erase
	input wire [1:0] erase_kind_o // Kind
);
	logic [3:0] mode_r;
	wire normal = &mode_r;
	// Cleared in reset so the shadow load after release is never judged as a normal write
	always @(posedge clk_i) begin
		if (!reset_n_i)
			mode_r <= 4'h0;
		else
			mode_r <= {mode_r[2:0], special_mode_n_i};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_dbg; normal |-> $stable(debug_lockout_o); endproperty
	property p_open; normal |-> !$rose(flash_write_open_o); endproperty
	property p_clk; !$past(wait_mode_i) |-> module_clock_en_o; endproperty
	property p_pgm; $rose(program_voltage_enable_o) |-> $past(latch_enable_o); endproperty
	property p_frz;
		$past(program_voltage_enable_o) |-> $stable(latch_enable_o) && $stable(erase_config_o);
	endproperty
	property p_kind; erase_kind_o != 2'h0 |-> erase_config_o; endproperty
	property p_sel;
		!($past(array_addr_i) inside {12'h0fc0, 12'h0fc1}) |-> !shadow_select_o;
	endproperty
	property p_test; normal && read_i && address_i[9:2] == 8'hf1 |=> readdata_o[7:0] == 8'h00;
	endproperty
	a_dbg: assert property (p_dbg) else $error("lockout changed in normal mode");
	a_open: assert property (p_open) else $error("flash open set in normal mode");
	a_clk: assert property (p_clk) else $error("clock stopped outside wait");
	a_pgm: assert property (p_pgm) else $error("voltage set without latch");
	a_frz: assert property (p_frz) else $error("bits changed under voltage");
	a_kind: assert property (p_kind) else $error("erase kind without erase");
	a_sel: assert property (p_sel) else $error("redirect off shadow address");
	a_test: assert property (p_test) else $error("test register nonzero");
	c_pgm: cover property ($rose(program_voltage_enable_o));
	c_bulk: cover property (erase_kind_o == 2'h3);
	c_stop: cover property (!module_clock_en_o);
endmodule // eeprom_regs_chk
bind eeprom_config_and_control_regs eeprom_regs_chk eeprom_regs_chk_i (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .address_i(address_i), .read_i(read_i), .readdata_o(readdata_o),
	.special_mode_n_i(special_mode_n_i), .wait_mode_i(wait_mode_i),
	.array_addr_i(array_addr_i), .shadow_select_o(shadow_select_o),
	.debug_lockout_o(debug_lockout_o), .flash_write_open_o(flash_write_open_o),
	.module_clock_en_o(module_clock_en_o), .latch_enable_o(latch_enable_o),
	.program_voltage_enable_o(program_voltage_enable_o), .erase_config_o(erase_config_o),
	.erase_kind_o(erase_kind_o));
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the EEPROM register block
// Assumes: One Avalon request at a time, shadow word constant
// Notes: A register model predicts every readback and every output but waitrequest
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i, reset_n_i, rd_i, wr_i, smn, wm, done, once;
	logic [9:0] adr, dvm;
	logic [31:0] wd, rd, seed;
	logic [11:0] aa;
	logic [7:0] mc, pe;
	logic [7:0] seq [8];
	wire [31:0] rdo;
	wire wrq, ss, dl, fo, ce, le, pv, ec, pa;
	wire [1:0] ek;
	wire [9:0] dv;
	int err_count, total_checks;
	eeprom_config_and_control_regs eeprom_config_and_control_regs_i (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .address_i(adr), .read_i(rd_i), .write_i(wr_i),
		.writedata_i(wd), .byteenable_i(4'hf), .readdata_o(rdo), .waitrequest_o(wrq),
		.special_mode_n_i(smn), .wait_mode_i(wm), .cycle_done_i(done),
		.shadow_high_i(8'hf3), .shadow_low_i(8'h05), .array_addr_i(aa),
		.shadow_select_o(ss), .debug_lockout_o(dl), .flash_write_open_o(fo),
		.module_clock_en_o(ce), .latch_enable_o(le), .program_voltage_enable_o(pv),
		.erase_config_o(ec), .erase_kind_o(ek), .pe_active_o(pa), .divider_o(dv));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		rd_i <= !w;
		wr_i <= w;
		adr <= {idx, 2'h0};
		wd <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 16) begin
				err_count++;
				results;
			end
		end while (wrq !== 1'b0);
		rd = rdo;
		rd_i <= 1'b0;
		wr_i <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk("readdata", {24'h00_0000, e}, rd);
	endtask
	// Outputs trail the registers by a cycle, so two edges pass before looking
	task automatic outs;
		logic [1:0] k;
		k = !pe[2] ? 2'h0 : pe[4] ? 2'h1 : pe[7] ? 2'h0 : pe[3] ? 2'h2 : {2{!mc[6]}};
		repeat (2) @(posedge clk_i);
		chk("outputs", {!mc[7], mc[4], !(mc[2] & wm), pe[2:0], k, (aa[11:1] == 11'h7e0) & !mc[6],
			pe[0] & (dvm != 10'h000)}, {dl, fo, ce, ec, le, pv, ek, ss, pa});
	endtask
	task automatic wcfg(input logic [7:0] d);
		bus(1'b1, 8'hf0, d);
		if (!smn)
			mc = {d[7:4], 1'b1, d[2:0]};
		else begin
			mc[4] = mc[4] & d[4];
			mc[1] = once ? mc[1] : d[1];
			once = 1'b1;
			mc[2] = d[2];
			mc[0] = d[0];
		end
		rchk(8'hf0, mc);
		outs;
	endtask
	task automatic wpe(input logic [7:0] d);
		bus(1'b1, 8'hf3, d);
		if (pe[0])
			pe[0] = d[0];
		else begin
			pe[7] = mc[1] ? pe[7] : d[7];
			pe[5:2] = d[5:2];
			pe[0] = d[0] & pe[1];
			pe[1] = d[1];
		end
		rchk(8'hf3, pe);
		outs;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		reset_n_i = 1'b0;
		rd_i = 1'b0;
		wr_i = 1'b0;
		smn = 1'b1;
		wm = 1'b0;
		done = 1'b0;
		adr = 10'h000;
		wd = 32'h0000_0000;
		aa = 12'h0fc2;
		err_count = 0;
		total_checks = 0;
		seed = 32'h9fa3_0a87;
		// Shadow bits 6..4 stay erased, so the reset view has hide and test set
		mc = 8'hfc;
		pe = 8'h80;
		dvm = 10'h305;
		once = 1'b0;
		seq = '{8'h00, 8'h03, 8'h03, 8'h3d, 8'h02, 8'h00, 8'h22, 8'h23};
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("divider", {22'h00_0000, dvm}, {22'h00_0000, dv});
		rchk(8'hf0, mc);
		rchk(8'hf3, pe);
		rchk(8'hf1, 8'h00);
		rchk(8'h10, 8'h00);
		outs;
		aa <= 12'h0fc1;
		outs;
		wcfg(8'hff);
		repeat (6) begin
			seed = xs(seed);
			wcfg(seed[7:0]);
		end
		wcfg(8'h04);
		wm <= 1'b1;
		outs;
		wm <= 1'b0;
		wcfg(8'h00);
		wm <= 1'b1;
		outs;
		wm <= 1'b0;
		foreach (seq[i]) wpe(seq[i]);
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		pe[0] = 1'b0;
		rchk(8'hf3, pe);
		outs;
		smn <= 1'b0;
		repeat (4) @(posedge clk_i);
		wcfg(8'h12);
		wcfg(8'h10);
		wpe(8'h0c);
		wpe(8'h04);
		wcfg(8'h50);
		wpe(8'h04);
		wpe(8'h94);
		// Test register only holds data in special mode
		bus(1'b1, 8'hf1, 8'h5a);
		rchk(8'hf1, 8'h5a);
		smn <= 1'b1;
		repeat (4) @(posedge clk_i);
		rchk(8'hf1, 8'h00);
		wcfg(8'h10);
		wcfg(8'h00);
		wcfg(8'h10);
		// First normal divider write lands, a second one is refused
		bus(1'b1, 8'hf4, 8'h23);
		dvm[7:0] = 8'h23;
		rchk(8'hf4, 8'h23);
		bus(1'b1, 8'hf2, 8'h00);
		rchk(8'hf2, {6'h00, dvm[9:8]});
		chk("divider", {22'h00_0000, dvm}, {22'h00_0000, dv});
		results;
	end
endmodule // tb
`default_nettype wire
